/* File: gpsi_global.v */
// Functional notes
// - each pin has a two-bit select: input, port status, constant 0, constant 1
// - status code drives port k status A on pin 2k-1, B on pin 2k
// - pin 8 select ignored while update mode uses pin 8 as update input
// - pin 6 select ignored while error insertion is sourced from pin 6
// - pin 4 select ignored while pin 4 is the 8 kHz reference input
// - pin 2 select ignored while pin 2 carries the 8 kHz reference output
// - port summary bits 7..4 follow whether any port interrupt status is set
// - interrupt pin low when an enabled port summary bit is set
// - global summary bit 0 set while any enabled latched status is set
// - interrupt pin low when global summary set and its enable is one
// - live unlock bit 1 high when any clock-adapter PLL is unlocked
// - live update-complete bit is request AND done of globally updated ports
// - 8 kHz activity latched bit 4 set on pin 4 activity when selected
// - clock-reference activity latched bit 3 set on primary clock activity
// - one-second latched bit 2 set every second, enable bit 2
// - unlock latched bit 1 set on rising live unlock, enable bit 1
// - update latched bit 0 set on rising live update-complete, enable bit 0
// - pin readback bits 7..0 give present levels of the eight pins
// - latched bits clear on read if clear-on-read is one, else on write
// - interrupt pin drives low active; inactive floats or drives high by mode
`timescale 1ns/1ns
`include "gpsi_map.vh"

module gpsi_global #(
	parameter        NUM_PLL         = 3,                     // clock-adapter PLL count
	parameter [31:0] ONE_SEC_CYCLES  = `GPSI_ONE_SEC_CYCLES   // core clocks per second
) (
	input  wire               clk_i,                 // core clock, 25 MHz
	input  wire               sys_rst_i,             // synchronous reset, active high
	// microprocessor port
	input  wire               bus_cs_i,              // chip select, active high
	input  wire               bus_rd_i,              // read strobe, one cycle per access
	input  wire               bus_wr_i,              // write strobe, one cycle per access
	input  wire [7:0]         bus_addr_i,            // byte address
	input  wire [15:0]        bus_wdata_i,           // write data
	output reg  [15:0]        bus_rdata_o,           // read data, registered
	output reg                bus_rvalid_o,          // read data valid pulse
	// global controls held elsewhere
	input  wire [1:0]         global_pm_update_mode_i,    // update mode
	input  wire               global_error_insert_source_i, // 1: pin 6 is error insert
	input  wire               ref8k_input_select_i,  // 1: pin 4 is 8 kHz input
	input  wire               ref8k_output_select_i, // 1: pin 2 is 8 kHz output
	input  wire               clear_on_read_control_i, // 1: latched bits clear on read
	input  wire               interrupt_pin_mode_i,  // 1: drive high when inactive
	input  wire               global_update_request_i, // global update request bit
	input  wire               ref8k_out_i,           // internal 8 kHz reference out
	// port side
	input  wire [3:0]         port_status_a_i,       // selected A status, port 1 bit 0
	input  wire [3:0]         port_status_b_i,       // selected B status, port 1 bit 0
	input  wire [3:0]         port_isr_any_i,        // any port interrupt status set
	input  wire [3:0]         port_update_done_i,    // port update done
	input  wire [3:0]         port_update_mode_i,    // 1: port on global update
	// clock adapter
	input  wire [NUM_PLL-1:0] pll_unlock_i,          // per-PLL not locked
	input  wire               primary_clock_input_i, // sampled primary clock pin
	// pins
	input  wire [7:0]         gpio_i,                // pad levels, pin 1 in bit 0
	output wire [7:0]         gpio_o,                // pad drive levels
	output wire [7:0]         gpio_oe_n_o,           // low while pad driven
	output wire               ref8k_in_o,            // 8 kHz reference from pin 4
	output wire               error_insert_pin_o,    // error insert from pin 6
	output wire               pm_update_pin_o,       // update strobe from pin 8
	output reg                int_n_o,               // interrupt pad level
	output reg                int_n_oe_n_o           // low while interrupt pad driven
);

	// writable registers
	reg [15:0] pin_sel_r;
	reg [15:0] isr_en_r;
	reg [15:0] sr_en_r;

	// latched status and edge history
	reg [4:0]  lat_r;
	reg [4:0]  lat_nxt;
	reg        unlock_d_r;
	reg        upd_d_r;
	reg        ref8k_d_r;
	reg        clkref_d_r;
	reg        history_ok_r;
	reg [31:0] sec_cnt_r;
	reg        sec_tick_r;

	// bus decode
	wire       rd_stb;
	wire       wr_stb;
	wire       sel_pin_sel;
	wire       sel_isr_en;
	wire       sel_lat;
	wire       sel_sr_en;

	// live state
	wire       unlock_live;
	wire       upd_live;
	wire [4:0] lat_set;
	wire [4:0] lat_clr;
	wire       global_summary_status;
	wire [3:0] port_sum;
	wire       irq;
	wire [15:0] isr_word;
	wire [15:0] live_word;
	wire [15:0] lat_word;
	wire [15:0] pinrd_word;
	reg  [15:0] rd_mux;
	wire       pm_pin_mode;

	// rising edge of a level; ok stays low for the first cycle after reset
	function gpsi_rise;
		input cur;
		input prev;
		input ok;
		begin
			gpsi_rise = ok & cur & ~prev;
		end
	endfunction

	// activity is any change of a sampled pin; a pin stuck at either level
	// never counts, at the price that a slow reference shows activity only
	// once per level change
	function gpsi_toggle;
		input cur;
		input prev;
		input ok;
		begin
			gpsi_toggle = ok & (cur ^ prev);
		end
	endfunction

	assign rd_stb      = bus_cs_i & bus_rd_i;
	assign wr_stb      = bus_cs_i & bus_wr_i;
	assign sel_pin_sel = (bus_addr_i == `GPSI_ADDR_PIN_SEL);
	assign sel_isr_en  = (bus_addr_i == `GPSI_ADDR_ISR_EN);
	assign sel_lat     = (bus_addr_i == `GPSI_ADDR_LATCHED);
	assign sel_sr_en   = (bus_addr_i == `GPSI_ADDR_SR_EN);

	// writable registers; summary, live status and readback offsets simply have no write path
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_sel_r <= `GPSI_RST_PIN_SEL;
			isr_en_r  <= `GPSI_RST_ISR_EN;
			sr_en_r   <= `GPSI_RST_SR_EN;
		end else if (wr_stb) begin
			if (sel_pin_sel) begin
				pin_sel_r <= bus_wdata_i;
			end
			// only enable bits that exist are kept, the rest read as zero
			if (sel_isr_en) begin
				isr_en_r <= bus_wdata_i & 16'h00F1;
			end
			if (sel_sr_en) begin
				sr_en_r <= bus_wdata_i & 16'h0007;
			end
		end
	end

	// live status: unlock is an OR over PLLs, update-complete an AND over
	// ports on global update, forced low while the request is low
	assign unlock_live = |pll_unlock_i;
	assign upd_live    = global_update_request_i &
		(&(port_update_done_i | ~port_update_mode_i));

	// one-second tick from a free-running cycle counter
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			sec_cnt_r  <= 32'h00000000;
			sec_tick_r <= 1'b0;
		end else if (sec_cnt_r >= ONE_SEC_CYCLES - 32'h00000001) begin
			sec_cnt_r  <= 32'h00000000;
			sec_tick_r <= 1'b1;
		end else begin
			sec_cnt_r  <= sec_cnt_r + 32'h00000001;
			sec_tick_r <= 1'b0;
		end
	end

	// edge history; edges are ignored in the first cycle after reset so that
	// a level already present at release is not mistaken for an event
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			unlock_d_r   <= 1'b0;
			upd_d_r      <= 1'b0;
			ref8k_d_r    <= 1'b0;
			clkref_d_r   <= 1'b0;
			history_ok_r <= 1'b0;
		end else begin
			unlock_d_r   <= unlock_live;
			upd_d_r      <= upd_live;
			ref8k_d_r    <= gpio_i[3]; // raw pin, so a select change is no event
			clkref_d_r   <= primary_clock_input_i;
			history_ok_r <= 1'b1;
		end
	end

	// set conditions of the latched bits
	assign lat_set[`GPSI_LAT_UPDATE_BIT] = gpsi_rise(upd_live, upd_d_r, history_ok_r);
	assign lat_set[`GPSI_LAT_UNLOCK_BIT] = gpsi_rise(unlock_live, unlock_d_r, history_ok_r);
	assign lat_set[`GPSI_LAT_ONESEC_BIT] = sec_tick_r;
	// pin 4 is watched only while it is selected as the reference input
	assign lat_set[`GPSI_LAT_CLKREF_BIT] = gpsi_toggle(primary_clock_input_i, clkref_d_r,
		history_ok_r);
	assign lat_set[`GPSI_LAT_REF8K_BIT]  = ref8k_input_select_i &
		gpsi_toggle(gpio_i[3], ref8k_d_r, history_ok_r);

	// clear: by read of the latched register, or by writing ones to it
	assign lat_clr = (rd_stb & sel_lat & clear_on_read_control_i) ? lat_r :
		((wr_stb & sel_lat & ~clear_on_read_control_i) ? bus_wdata_i[4:0] : 5'h00);

	// set wins over a clear in the same cycle
	always @* begin
		lat_nxt = (lat_r & ~lat_clr) | lat_set;
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			lat_r <= 5'h00;
		end else begin
			lat_r <= lat_nxt;
		end
	end

	// summaries: reference activity bits have no enable and never interrupt
	assign global_summary_status      = |(lat_r[2:0] & sr_en_r[2:0]);
	assign port_sum = port_isr_any_i;
	assign irq      = (|(port_sum & isr_en_r[`GPSI_ISR_PORT_MSB:`GPSI_ISR_PORT_LSB])) |
		(global_summary_status & isr_en_r[`GPSI_ISR_GLOBAL_BIT]);

	// interrupt pad: low when active, float or high when idle
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			int_n_o      <= 1'b1;
			int_n_oe_n_o <= 1'b1;
		end else if (irq) begin
			int_n_o      <= 1'b0;
			int_n_oe_n_o <= 1'b0;
		end else begin
			int_n_o      <= 1'b1;
			int_n_oe_n_o <= ~interrupt_pin_mode_i;
		end
	end

	// read words; unused bits read as zero
	assign isr_word   = {8'h00, port_sum, 3'h0, global_summary_status};
	assign live_word  = {14'h0000, unlock_live, upd_live};
	assign lat_word   = {11'h000, lat_r};
	assign pinrd_word = {8'h00, gpio_i};

	// read mux; an unmapped address reads zero
	always @* begin
		case (bus_addr_i)
			`GPSI_ADDR_PIN_SEL:  rd_mux = pin_sel_r;
			`GPSI_ADDR_ISR:      rd_mux = isr_word;
			`GPSI_ADDR_ISR_EN:   rd_mux = isr_en_r;
			`GPSI_ADDR_LIVE:     rd_mux = live_word;
			`GPSI_ADDR_LATCHED:  rd_mux = lat_word;
			`GPSI_ADDR_SR_EN:    rd_mux = sr_en_r;
			`GPSI_ADDR_PIN_READ: rd_mux = pinrd_word;
			default:             rd_mux = 16'h0000;
		endcase
	end

	// read data is captured before any clear-on-read takes effect
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			bus_rdata_o  <= 16'h0000;
			bus_rvalid_o <= 1'b0;
		end else begin
			bus_rvalid_o <= rd_stb;
			if (rd_stb) begin
				bus_rdata_o <= rd_mux;
			end
		end
	end

	// pins borrowed by global functions; the borrowed signal reads low
	// whenever its function is not selected
	// update mode 01 borrows pin 8; decoded once for the strobe and the override
	assign pm_pin_mode        = (global_pm_update_mode_i == `GPSI_PM_MODE_PIN);
	assign ref8k_in_o         = ref8k_input_select_i & gpio_i[3];
	assign error_insert_pin_o = global_error_insert_source_i & gpio_i[5];
	assign pm_update_pin_o    = pm_pin_mode & gpio_i[7];

	wire [7:0] ovr;
	wire [7:0] ovr_oe;
	wire [7:0] ovr_val;

	// pin 2 becomes an output, pins 4, 6 and 8 become inputs
	assign ovr     = {pm_pin_mode, 1'b0,
		global_error_insert_source_i, 1'b0, ref8k_input_select_i, 1'b0,
		ref8k_output_select_i, 1'b0};
	assign ovr_oe  = {6'h00, ref8k_output_select_i, 1'b0};
	assign ovr_val = {6'h00, ref8k_out_i, 1'b0};

	gpsi_pin_mux u_pin_mux (
		.clk_i           (clk_i),
		.sys_rst_i       (sys_rst_i),
		.pin_sel_i       (pin_sel_r),
		.port_status_a_i (port_status_a_i),
		.port_status_b_i (port_status_b_i),
		.pin_override_i  (ovr),
		.override_oe_i   (ovr_oe),
		.override_val_i  (ovr_val),
		.gpio_o          (gpio_o),
		.gpio_oe_n_o     (gpio_oe_n_o)
	);

endmodule

/* File: gpsi_global_bench.sv */
`timescale 1ns/1ns
`include "gpsi_map.vh"
module gpsi_global_bench;
	localparam SEC = 16;
	// rows: select, status a, status b, expected drive level, expected enables
	localparam logic [39:0] ROWS [6] = '{
		{16'h0000, 4'h0, 4'h0, 8'h00, 8'hFF}, {16'hAAAA, 4'h0, 4'h0, 8'h00, 8'h00},
		{16'hFFFF, 4'h0, 4'h0, 8'hFF, 8'h00}, {16'h5555, 4'h5, 4'h3, 8'h1B, 8'h00},
		{16'h5555, 4'hA, 4'hC, 8'hE4, 8'h00}, {16'hE4E4, 4'h0, 4'hF, 8'hAA, 8'h11}};
	logic        clk_i = 0, sys_rst_i = 1, cs = 0, rs = 0, ws = 0, eis = 0, kis = 0;
	logic        kos = 0, cor = 0, ipm = 0, req = 0, ko = 0, pclk = 0;
	logic [1:0]  pmm = 0;
	logic [2:0]  pll = 0;
	logic [3:0]  sa = 0, sb = 0, isr = 0, dn = 0, um = 0;
	logic [7:0]  ad = 0, gi = 0;
	logic [15:0] wd = 0, q;
	wire  [15:0] rdat;
	wire  [7:0]  go, goe;
	wire         rv, ki, ei, pu, irq, irq_oe;
	integer      errors = 0, checks = 0, cyc = 0, i;

	gpsi_global #(.ONE_SEC_CYCLES(SEC)) dut_u (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_cs_i(cs), .bus_rd_i(rs), .bus_wr_i(ws),
		.bus_addr_i(ad), .bus_wdata_i(wd), .bus_rdata_o(rdat), .bus_rvalid_o(rv),
		.global_pm_update_mode_i(pmm), .global_error_insert_source_i(eis),
		.ref8k_input_select_i(kis), .ref8k_output_select_i(kos), .clear_on_read_control_i(cor),
		.interrupt_pin_mode_i(ipm), .global_update_request_i(req), .ref8k_out_i(ko),
		.port_status_a_i(sa), .port_status_b_i(sb), .port_isr_any_i(isr),
		.port_update_done_i(dn), .port_update_mode_i(um), .pll_unlock_i(pll),
		.primary_clock_input_i(pclk), .gpio_i(gi), .gpio_o(go), .gpio_oe_n_o(goe),
		.ref8k_in_o(ki), .error_insert_pin_o(ei), .pm_update_pin_o(pu), .int_n_o(irq),
		.int_n_oe_n_o(irq_oe));

	always #20 clk_i = ~clk_i;

	// a hung run would otherwise never report
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errors = errors + 1;
			conclude();
		end
	end

	task conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks = checks + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task wt(input integer n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// strobes last one cycle so clear-on-read acts once per access
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		cs <= 1;
		ws <= 1;
		ad <= a;
		wd <= d;
		@(posedge clk_i);
		cs <= 0;
		ws <= 0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk_i);
		cs <= 1;
		rs <= 1;
		ad <= a;
		@(posedge clk_i);
		cs <= 0;
		rs <= 0;
		#1 q = rdat;
	endtask

	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 0;
		wt(1);
		chk("rst_oe", 16'h00FF, goe);
		chk("rst_irq", 16'h0003, {irq, irq_oe});
		// enable registers, read-only places and an unmapped address
		rd(`GPSI_ADDR_ISR_EN);
		chk("isr_en_rst", 16'h0000, q);
		rd(`GPSI_ADDR_SR_EN);
		chk("sr_en_rst", 16'h0000, q);
		wr(`GPSI_ADDR_ISR_EN, 16'hFFFF);
		rd(`GPSI_ADDR_ISR_EN);
		chk("isr_en", 16'h00F1, q);
		wr(`GPSI_ADDR_SR_EN, 16'hFFFF);
		rd(`GPSI_ADDR_SR_EN);
		chk("sr_en", 16'h0007, q);
		wr(`GPSI_ADDR_LIVE, 16'hFFFF);
		rd(`GPSI_ADDR_LIVE);
		chk("live_ro", 16'h0000, q);
		rd(8'h1E);
		chk("unmapped", 16'h0000, q);
		gi <= 8'h5A;
		rd(`GPSI_ADDR_PIN_READ);
		chk("pin_read", 16'h005A, q);
		wr(`GPSI_ADDR_ISR_EN, 16'h0000);
		wr(`GPSI_ADDR_SR_EN, 16'h0002);
		// every select code on every pin
		for (i = 0; i < 6; i = i + 1) begin
			sa <= ROWS[i][23:20];
			sb <= ROWS[i][19:16];
			wr(`GPSI_ADDR_PIN_SEL, ROWS[i][39:24]);
			wt(1);
			chk("pin_oe", ROWS[i][7:0], goe);
			chk("pin_out", ROWS[i][15:8], go & ~ROWS[i][7:0]);
		end
		// global functions take pins 2, 4, 6 and 8 over
		wr(`GPSI_ADDR_PIN_SEL, 16'hFFFF);
		kis <= 1;
		kos <= 1;
		eis <= 1;
		pmm <= 2'h1;
		ko <= 1;
		gi <= 8'hA8;
		wt(2);
		chk("ovr_oe", 16'h00A8, goe);
		chk("ovr_out", 16'h0057, go & 8'h57);
		chk("ovr_in", 16'h0007, {ki, ei, pu});
		ko <= 0;
		wt(2);
		chk("ref_out", 16'h0000, go[1]);
		kis <= 0;
		kos <= 0;
		eis <= 0;
		pmm <= 2'h0;
		wt(2);
		chk("ovr_off", 16'h0000, goe);
		// port summary interrupt, masked, then idle drive mode
		isr <= 4'h4;
		wr(`GPSI_ADDR_ISR_EN, 16'h0040);
		wt(2);
		chk("irq_port", 16'h0000, {irq, irq_oe});
		rd(`GPSI_ADDR_ISR);
		chk("port_sum", 16'h0040, q & 16'h00F0);
		wr(`GPSI_ADDR_ISR_EN, 16'h0020);
		wt(2);
		chk("irq_mask", 16'h0003, {irq, irq_oe});
		ipm <= 1;
		wt(2);
		chk("irq_idle", 16'h0002, {irq, irq_oe});
		isr <= 4'h0;
		// lock loss through the global summary, cleared by a write
		wr(`GPSI_ADDR_ISR_EN, 16'h0001);
		pll <= 3'h2;
		wt(3);
		rd(`GPSI_ADDR_LIVE);
		chk("live_unlock", 16'h0002, q);
		rd(`GPSI_ADDR_LATCHED);
		chk("lat_unlock", 16'h0002, q & 16'h0003);
		rd(`GPSI_ADDR_ISR);
		chk("glob_sum", 16'h0001, q & 16'h0001);
		chk("irq_glob", 16'h0000, irq);
		wr(`GPSI_ADDR_LATCHED, 16'h0002);
		wt(2);
		rd(`GPSI_ADDR_LATCHED);
		chk("lat_wclr", 16'h0000, q & 16'h0003);
		chk("irq_gone", 16'h0001, irq);
		// update request held high until complete, then lowered
		um <= 4'h3;
		dn <= 4'h1;
		req <= 1;
		rd(`GPSI_ADDR_LIVE);
		chk("upd_wait", 16'h0002, q);
		dn <= 4'h3;
		rd(`GPSI_ADDR_LIVE);
		chk("upd_done", 16'h0003, q);
		req <= 0;
		cor <= 1;
		rd(`GPSI_ADDR_LATCHED);
		chk("lat_upd", 16'h0001, q & 16'h0001);
		rd(`GPSI_ADDR_LATCHED);
		chk("lat_rclr", 16'h0000, q & 16'h0003);
		// one-second tick, latched and interrupting
		wt(SEC + 2);
		rd(`GPSI_ADDR_LATCHED);
		chk("one_sec", 16'h0004, q & 16'h0004);
		wr(`GPSI_ADDR_SR_EN, 16'h0004);
		wt(SEC + 2);
		chk("irq_sec", 16'h0000, irq);
		wr(`GPSI_ADDR_SR_EN, 16'h0000);
		// pin 4 activity counts only while selected; clock pin activity
		gi <= gi ^ 8'h08;
		wt(3);
		rd(`GPSI_ADDR_LATCHED);
		gi <= gi ^ 8'h08;
		wt(3);
		rd(`GPSI_ADDR_LATCHED);
		chk("ref8k_off", 16'h0000, q & 16'h0010);
		kis <= 1;
		wt(3);
		rd(`GPSI_ADDR_LATCHED);
		gi <= gi ^ 8'h08;
		pclk <= 1;
		wt(3);
		rd(`GPSI_ADDR_LATCHED);
		chk("activity", 16'h0018, q & 16'h0018);
		// mid-run reset with unlock and clock pin high: no false event after release
		sys_rst_i <= 1;
		wt(2);
		sys_rst_i <= 0;
		wt(1);
		chk("rst2_oe", 16'h00FF, goe);
		chk("rst2_irq", 16'h0002, {irq, irq_oe});
		rd(`GPSI_ADDR_SR_EN);
		chk("rst2_sr_en", 16'h0000, q);
		rd(`GPSI_ADDR_LATCHED);
		chk("rst2_lat", 16'h0000, q & 16'h001F);
		conclude();
	end
endmodule

/* File: gpsi_global_sva.sv */
`timescale 1ns/1ns
`include "gpsi_map.vh"
// port-level checker: ties pad and read data to their causes, no register shadows kept
module gpsi_global_sva #(
	parameter        NUM_PLL        = 3,  // pll count
	parameter [31:0] ONE_SEC_CYCLES = `GPSI_ONE_SEC_CYCLES  // clocks per second
) (
	input wire               clk_i,                        // clock
	input wire               sys_rst_i,                    // reset
	input wire               bus_cs_i,                     // select
	input wire               bus_rd_i,                     // read
	input wire [7:0]         bus_addr_i,                   // address
	input wire [15:0]        bus_rdata_o,                  // read data
	input wire               bus_rvalid_o,                 // read valid
	input wire [1:0]         global_pm_update_mode_i,      // update mode
	input wire               global_error_insert_source_i, // pin 6 taken
	input wire               ref8k_input_select_i,         // pin 4 taken
	input wire               ref8k_output_select_i,        // pin 2 taken
	input wire               interrupt_pin_mode_i,         // idle drive
	input wire               global_update_request_i,      // request
	input wire               ref8k_out_i,                  // 8k out
	input wire [3:0]         port_isr_any_i,               // port status
	input wire [3:0]         port_update_done_i,           // port done
	input wire [3:0]         port_update_mode_i,           // port global
	input wire [NUM_PLL-1:0] pll_unlock_i,                 // unlocked
	input wire [7:0]         gpio_i,                       // pads in
	input wire [7:0]         gpio_o,                       // pads out
	input wire [7:0]         gpio_oe_n_o,                  // pad enables
	input wire               int_n_o,                      // irq level
	input wire               int_n_oe_n_o                  // irq enable
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// one read strobe at a given address; answer lands one edge later
	sequence rd_at(logic [7:0] a);
		bus_cs_i && bus_rd_i && bus_addr_i == a;
	endsequence

	// pins 4, 6 and 8 borrowed by a global function fall back to input; borrowed pin 2 drives the reference output
	pin8_free_a: assert property (
		global_pm_update_mode_i == `GPSI_PM_MODE_PIN |=> gpio_oe_n_o[7])
		else $error("pin 8 driven while used as update input");
	pin6_free_a: assert property (
		global_error_insert_source_i |=> gpio_oe_n_o[5])
		else $error("pin 6 driven while used as error input");
	pin4_free_a: assert property (
		ref8k_input_select_i |=> gpio_oe_n_o[3])
		else $error("pin 4 driven while used as reference input");
	ref_out_a: assert property (
		ref8k_output_select_i |=> !gpio_oe_n_o[1] && gpio_o[1] == $past(ref8k_out_i))
		else $error("pin 2 does not carry the reference output");
	pin_read_a: assert property (
		rd_at(`GPSI_ADDR_PIN_READ) |=> bus_rvalid_o && bus_rdata_o[7:0] == $past(gpio_i))
		else $error("pin readback differs from pad levels");
	port_sum_a: assert property (
		rd_at(`GPSI_ADDR_ISR) |=> bus_rdata_o[7:4] == $past(port_isr_any_i))
		else $error("port summary bits differ from port status");
	unlock_live_a: assert property (
		rd_at(`GPSI_ADDR_LIVE) |=> bus_rdata_o[1] == $past(|pll_unlock_i))
		else $error("live unlock bit wrong");
	update_live_a: assert property (
		rd_at(`GPSI_ADDR_LIVE) |=> bus_rdata_o[0] == $past(global_update_request_i
		& (&(port_update_done_i | ~port_update_mode_i))))
		else $error("live update complete bit wrong");
	irq_drive_a: assert property (
		!int_n_o |-> !int_n_oe_n_o)
		else $error("interrupt low but not driven");
	irq_idle_a: assert property (
		int_n_o && !$past(sys_rst_i) |-> int_n_oe_n_o == !$past(interrupt_pin_mode_i))
		else $error("idle interrupt pad mode wrong");
endmodule

bind gpsi_global gpsi_global_sva #(.NUM_PLL(NUM_PLL), .ONE_SEC_CYCLES(ONE_SEC_CYCLES)) sva_u (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_cs_i(bus_cs_i), .bus_rd_i(bus_rd_i),
	.bus_addr_i(bus_addr_i), .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o),
	.global_pm_update_mode_i(global_pm_update_mode_i),
	.global_error_insert_source_i(global_error_insert_source_i),
	.ref8k_input_select_i(ref8k_input_select_i), .ref8k_output_select_i(ref8k_output_select_i),
	.interrupt_pin_mode_i(interrupt_pin_mode_i), .global_update_request_i(global_update_request_i),
	.ref8k_out_i(ref8k_out_i), .port_isr_any_i(port_isr_any_i),
	.port_update_done_i(port_update_done_i), .port_update_mode_i(port_update_mode_i),
	.pll_unlock_i(pll_unlock_i), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_n_o(gpio_oe_n_o),
	.int_n_o(int_n_o), .int_n_oe_n_o(int_n_oe_n_o));

/* File: gpsi_map.vh */
`ifndef GPSI_MAP_VH
`define GPSI_MAP_VH

// register byte offsets on the 16-bit microprocessor port
`define GPSI_ADDR_PIN_SEL       8'h0A
`define GPSI_ADDR_ISR           8'h10
`define GPSI_ADDR_ISR_EN        8'h12
`define GPSI_ADDR_LIVE          8'h14
`define GPSI_ADDR_LATCHED       8'h16
`define GPSI_ADDR_SR_EN         8'h18
`define GPSI_ADDR_PIN_READ      8'h1C

// summary register fields
`define GPSI_ISR_GLOBAL_BIT     0
`define GPSI_ISR_PORT_LSB       4
`define GPSI_ISR_PORT_MSB       7

// live status fields
`define GPSI_LIVE_UPDATE_BIT    0
`define GPSI_LIVE_UNLOCK_BIT    1

// latched status fields
`define GPSI_LAT_UPDATE_BIT     0
`define GPSI_LAT_UNLOCK_BIT     1
`define GPSI_LAT_ONESEC_BIT     2
`define GPSI_LAT_CLKREF_BIT     3
`define GPSI_LAT_REF8K_BIT      4

// pin function select codes
`define GPSI_FSEL_INPUT         2'h0
`define GPSI_FSEL_STATUS        2'h1
`define GPSI_FSEL_LOW           2'h2
`define GPSI_FSEL_HIGH          2'h3

// update mode code that borrows pin 8 as the update input
`define GPSI_PM_MODE_PIN        2'h1

// reset values of writable registers
`define GPSI_RST_PIN_SEL        16'h0000
`define GPSI_RST_ISR_EN         16'h0000
`define GPSI_RST_SR_EN          16'h0000

// timing: one second at the core clock
`define GPSI_ONE_SEC_NS         1000000000
`define GPSI_CLK_PERIOD_NS      40
`define GPSI_ONE_SEC_CYCLES     (`GPSI_ONE_SEC_NS / `GPSI_CLK_PERIOD_NS)

`endif

/* File: gpsi_pin_mux.v */
`timescale 1ns/1ns
`include "gpsi_map.vh"

// function mux for the eight general-purpose pins; outputs are registered
module gpsi_pin_mux (
	input  wire        clk_i,            // core clock
	input  wire        sys_rst_i,        // synchronous reset, active high
	input  wire [15:0] pin_sel_i,        // two-bit select per pin, pin 1 in bits 1:0
	input  wire [3:0]  port_status_a_i,  // per-port A status, port 1 in bit 0
	input  wire [3:0]  port_status_b_i,  // per-port B status, port 1 in bit 0
	input  wire [7:0]  pin_override_i,   // pin taken over by a global function
	input  wire [7:0]  override_oe_i,    // taken-over pin drives (else input)
	input  wire [7:0]  override_val_i,   // level driven on a taken-over pin
	output reg  [7:0]  gpio_o,           // pin drive level, pin 1 in bit 0
	output reg  [7:0]  gpio_oe_n_o       // low while the pin is driven
);

	// decode one pin: returns {drive, level}
	function [1:0] gpsi_pin_fn;
		input [1:0] sel;
		input       stat;
		begin
			case (sel)
				`GPSI_FSEL_INPUT:  gpsi_pin_fn = 2'h0;
				`GPSI_FSEL_STATUS: gpsi_pin_fn = {1'b1, stat};
				`GPSI_FSEL_LOW:    gpsi_pin_fn = 2'h2;
				`GPSI_FSEL_HIGH:   gpsi_pin_fn = 2'h3;
				default:           gpsi_pin_fn = 2'h0;
			endcase
		end
	endfunction

	reg [7:0] drv_nxt;
	reg [7:0] lvl_nxt;
	reg [1:0] fn;
	integer   k;

	// odd pin 2k-1 carries port k status A, even pin 2k carries status B
	always @* begin
		drv_nxt = 8'h00;
		lvl_nxt = 8'h00;
		fn = 2'h0;
		for (k = 0; k < 8; k = k + 1) begin
			fn = gpsi_pin_fn(pin_sel_i[2*k +: 2],
				(k % 2 == 0) ? port_status_a_i[k/2] : port_status_b_i[k/2]);
			if (pin_override_i[k]) begin
				drv_nxt[k] = override_oe_i[k];
				lvl_nxt[k] = override_val_i[k];
			end else begin
				drv_nxt[k] = fn[1];
				lvl_nxt[k] = fn[0];
			end
		end
	end

	// registered so that pins never glitch while selects settle
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			gpio_o      <= 8'h00;
			gpio_oe_n_o <= 8'hFF;
		end else begin
			gpio_o      <= lvl_nxt;
			gpio_oe_n_o <= ~drv_nxt;
		end
	end

endmodule
